// file: rtl/rst_ctl.sv
// Reset source recording, option byte application and reset sequencing.
`timescale 1ns/1ns
module rst_ctl
  import rst_ctl_pkg::*;
#(
  parameter logic [7:0] OPTION_BYTE = OPTION_ERASED,
  parameter int         POR_COUNT   = POR_SLOW_CYCLES,
  parameter int         CLK_DIV     = CPU_CLK_DIV
)
(
  // Clock and power-on reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Reset sources
  input  wire logic        reset_pin_b,
  input  wire logic        lowvolt0_ok,
  input  wire logic        lowvolt0_trip,
  input  wire logic        lowvolt1_trip,
  input  wire logic        lowvolt2_trip,
  input  wire logic        osc_stop_trip,
  input  wire logic        watchdog_trip,
  input  wire logic        sw_reset_req,
  input  wire logic        slow_internal_osc_tick,
  input  wire logic [1:0]  proc_mode,
  // CPU and option outputs
  output logic             cpu_reset_b,
  output logic             cpu_clk_en,
  output logic             watchdog_autostart_sel,
  output logic             count_source_protect_sel,
  output logic             code_protect_active,
  output logic             lowvolt0_threshold_sel,
  output logic             lowvolt0_start_sel,
  // Bus pins held during reset
  output logic             chip_select_zero_o,
  output logic             write_strobe_o,
  output logic             read_strobe_o,
  output logic             addr_latch_en_o,
  output logic             bus_clk_o,
  output logic             bus_pins_oe_b,
  output logic             port4_pullup_en
);

  typedef enum logic [1:0] {ST_POR_WAIT, ST_PIN_HELD, ST_HALTED, ST_RUN} seq_e;

  seq_e        seq_q;
  seq_e        seq_d;
  logic [5:0]  por_cnt_q;
  logic [2:0]  div_cnt_q;
  logic        cpu_reset_b_q;
  logic        cpu_clk_en_q;
  logic [7:0]  opt_q;
  logic        opt_use_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [6:0]  pins_q;
  logic        in_reset;
  logic        ev_valid;
  reset_src_e  ev_src;
  logic        apb_setup;
  logic        apb_wr;
  logic        hit_flags;
  logic        hit_opt;
  logic        hit_ctl;
  logic [31:0] rd_mux;
  logic        micro_mode;
  logic        lv0_reset;
  logic [4:0]  sel_d;
  logic [4:0]  sel_q;

  rst_evt_if ev ();

  // ----------------------------------------------------------------
  // Reset source selection
  // ----------------------------------------------------------------
  // Monitor 0 only resets when the start bit of the option byte is clear.
  assign lv0_reset = lowvolt0_trip & !opt_q[LV0_START_BIT];
  assign ev_valid = lv0_reset
                  | !reset_pin_b | lowvolt1_trip | lowvolt2_trip
                  | osc_stop_trip | watchdog_trip | sw_reset_req;
  assign ev_src = lv0_reset      ? SRC_LV0 :
                  !reset_pin_b   ? SRC_HW  :
                  lowvolt1_trip  ? SRC_LV1 :
                  lowvolt2_trip  ? SRC_LV2 :
                  osc_stop_trip  ? SRC_OSC :
                  watchdog_trip  ? SRC_WD  : SRC_SW;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign apb_setup = psel & !penable;
  assign apb_wr    = psel & penable & pwrite & pready_q;
  assign hit_flags = paddr == RESET_SOURCE_FLAGS_ADDR;
  assign hit_opt   = paddr == OPTION_SELECT_ADDR;
  assign hit_ctl   = paddr == CONTROL_STATUS_ADDR;
  assign micro_mode = proc_mode == MODE_MICRO;

  // Reserved bit 7 reads as zero, one legal undefined value.
  assign rd_mux = hit_flags ? {24'h0, 1'b0, ev.flags[6:0]} :
                  hit_opt   ? {24'h0, opt_q} :
                  hit_ctl   ? {28'h0, opt_use_q, code_protect_active, cpu_reset_b_q,
                               micro_mode} : 32'h0;

  assign ev.valid      = ev_valid;
  assign ev.src        = ev_src;
  assign ev.flag_wr    = apb_wr & hit_flags;
  assign ev.flag_wdata = pwdata[7:0];

  rst_flag_reg u_flags (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .ev      (ev)
  );

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
    else
    begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup & !(hit_flags | hit_opt | hit_ctl);
      // The option byte has no write path at all.
      prdata_q  <= (apb_setup & !pwrite) ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  assign in_reset = seq_q != ST_RUN;

  always_comb
  begin
    seq_d = seq_q;
    case (seq_q)
      ST_POR_WAIT:
        if (lowvolt0_ok & slow_internal_osc_tick
            & (por_cnt_q == 6'(POR_COUNT - 1)))
          seq_d = ST_RUN;
      ST_PIN_HELD:
        if (reset_pin_b)
          seq_d = ST_RUN;
      ST_HALTED:
        seq_d = ST_HALTED;
      ST_RUN:
        seq_d = ST_RUN;
      default:
        seq_d = ST_POR_WAIT;
    endcase
    // Oscillator stop halts until pin or monitor 0 reset cancels it.
    // A reset only holds the CPU; no path clears memory contents.
    if (lv0_reset)
      seq_d = ST_POR_WAIT;
    else if (!reset_pin_b)
      seq_d = ST_PIN_HELD;
    else if (osc_stop_trip)
      seq_d = ST_HALTED;
    else if (ev_valid & (seq_q == ST_RUN))
      seq_d = ST_PIN_HELD;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      seq_q <= ST_POR_WAIT;
    else
      seq_q <= seq_d;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      por_cnt_q <= 6'h00;
    else if (seq_q != ST_POR_WAIT | !lowvolt0_ok)
      por_cnt_q <= 6'h00;
    else if (slow_internal_osc_tick)
      por_cnt_q <= por_cnt_q + 6'h01;
  end

  // CPU clock is slow oscillator divided by 8 after any reset.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_cnt_q    <= 3'h0;
      cpu_clk_en_q <= 1'b0;
    end
    else if (in_reset)
    begin
      div_cnt_q    <= 3'h0;
      cpu_clk_en_q <= 1'b0;
    end
    else
    begin
      if (slow_internal_osc_tick)
        div_cnt_q <= (div_cnt_q == 3'(CLK_DIV - 1)) ? 3'h0 : div_cnt_q + 3'h1;
      cpu_clk_en_q <= slow_internal_osc_tick & (div_cnt_q == 3'(CLK_DIV - 1));
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cpu_reset_b_q <= 1'b0;
    else
      cpu_reset_b_q <= seq_d == ST_RUN;
  end

  // ----------------------------------------------------------------
  // Option byte application, latched after every reset outside microprocessor mode
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      opt_q     <= OPTION_ERASED;
      opt_use_q <= 1'b0;
    end
    else if (in_reset)
    begin
      opt_use_q <= !micro_mode;
      opt_q     <= micro_mode ? OPTION_ERASED : OPTION_BYTE;
    end
  end

  assign sel_d[0] = !opt_q[WD_AUTO_BIT];
  // Protection mode needs auto-start as well.
  assign sel_d[1] = !opt_q[CSP_BIT] & !opt_q[WD_AUTO_BIT];
  assign sel_d[2] = opt_q[CP_CANCEL_BIT] & !opt_q[CP_PROTECT_BIT];
  assign sel_d[3] = opt_q[LV0_THRESH_BIT] & (proc_mode == MODE_SINGLE);
  assign sel_d[4] = !opt_q[LV0_START_BIT];

  // Decoded selections are registered so that each output leaves a flop.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      sel_q <= 5'h00;
    else
      sel_q <= sel_d;
  end

  assign watchdog_autostart_sel   = sel_q[0];
  assign count_source_protect_sel = sel_q[1];
  assign code_protect_active      = sel_q[2];
  assign lowvolt0_threshold_sel   = sel_q[3];
  assign lowvolt0_start_sel       = sel_q[4];

  // ----------------------------------------------------------------
  // Pin states while reset is held
  // ----------------------------------------------------------------
  // Bits: 0 chip select, 1 write, 2 read, 3 latch, 4 bus clock, 5 drive off, 6 pull-up.
  // The bus clock toggles every cycle while the pins are held.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pins_q <= 7'h20;
    else if (in_reset & micro_mode)
      pins_q <= {1'b1, 1'b0, !pins_q[4], 1'b0, 1'b1, 1'b1, 1'b1};
    else
      pins_q <= 7'h20;
  end

  assign chip_select_zero_o = pins_q[0];
  assign write_strobe_o     = pins_q[1];
  assign read_strobe_o      = pins_q[2];
  assign addr_latch_en_o    = pins_q[3];
  assign bus_clk_o          = pins_q[4];
  assign bus_pins_oe_b      = pins_q[5];
  assign port4_pullup_en    = pins_q[6];

  assign pready      = pready_q;
  assign prdata      = prdata_q;
  assign pslverr     = pslverr_q;
  assign cpu_reset_b = cpu_reset_b_q;
  assign cpu_clk_en  = cpu_clk_en_q;

endmodule : rst_ctl

// file: shared/rst_ctl_pkg.sv
// Package with register map, field positions and timing counts for the reset controller.
package rst_ctl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] RESET_SOURCE_FLAGS_ADDR = 12'h018;
  localparam logic [11:0] OPTION_SELECT_ADDR      = 12'h01c;
  localparam logic [11:0] CONTROL_STATUS_ADDR     = 12'h020;

  // ----------------------------------------------------------------
  // Reset source flag bit positions
  // ----------------------------------------------------------------
  localparam int COLD_WARM_BIT = 0;
  localparam int HW_BIT        = 1;
  localparam int SW_BIT        = 2;
  localparam int WD_BIT        = 3;
  localparam int LV1_BIT       = 4;
  localparam int LV2_BIT       = 5;
  localparam int OSC_BIT       = 6;
  localparam int RSVD_BIT      = 7;

  // ----------------------------------------------------------------
  // Option byte bit positions and erased value
  // ----------------------------------------------------------------
  localparam int WD_AUTO_BIT     = 0;
  localparam int CP_CANCEL_BIT   = 2;
  localparam int CP_PROTECT_BIT  = 3;
  localparam int LV0_THRESH_BIT  = 5;
  localparam int LV0_START_BIT   = 6;
  localparam int CSP_BIT         = 7;
  localparam logic [7:0] OPTION_ERASED = 8'hff;

  // ----------------------------------------------------------------
  // Processor modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_EXPAND = 2'h1;
  localparam logic [1:0] MODE_MICRO  = 2'h3;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int POR_SLOW_CYCLES = 32;
  localparam int CPU_CLK_DIV     = 8;

  typedef enum logic [2:0] {
    SRC_HW, SRC_POR, SRC_LV0, SRC_LV1, SRC_LV2, SRC_OSC, SRC_WD, SRC_SW
  } reset_src_e;

endpackage : rst_ctl_pkg

// file: shared/rst_evt_if.sv
// Interface carrying one recorded reset event to the flag register.
`timescale 1ns/1ns
interface rst_evt_if;
  import rst_ctl_pkg::*;
  logic       valid;
  reset_src_e src;
  logic       flag_wr;
  logic [7:0] flag_wdata;
  logic [7:0] flags;
  modport src_side (output valid, output src, output flag_wr, output flag_wdata, input flags);
  modport reg_side (input valid, input src, input flag_wr, input flag_wdata, output flags);
endinterface : rst_evt_if

// file: rtl/rst_flag_reg.sv
// Reset source flag register with per-source update table.
`timescale 1ns/1ns
module rst_flag_reg
  import rst_ctl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Event side
  rst_evt_if.reg_side ev
);

  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] ev_next;
  logic [7:0] wr_next;

  // ----------------------------------------------------------------
  // Flag update for each reset source.
  // ----------------------------------------------------------------
  function automatic logic [7:0] src_update(input reset_src_e s, input logic [7:0] f);
    logic [7:0] r;
    r = 8'h00;
    r[COLD_WARM_BIT] = f[COLD_WARM_BIT];
    case (s)
      SRC_HW:
      begin
        r[HW_BIT]  = 1'b1;
        r[OSC_BIT] = f[OSC_BIT];
      end
      SRC_POR, SRC_LV0: r[COLD_WARM_BIT] = 1'b0;
      SRC_LV1: r[LV1_BIT] = 1'b1;
      SRC_LV2: r[LV2_BIT] = 1'b1;
      SRC_OSC: r[OSC_BIT] = 1'b1;
      SRC_WD:  r[WD_BIT]  = 1'b1;
      SRC_SW:  r[SW_BIT]  = 1'b1;
      default: r = f;
    endcase
    return r;
  endfunction : src_update

  assign ev_next = src_update(ev.src, flags_q);
  // Only the two writable bits respond to software; writing 1 to the oscillator flag is ignored.
  assign wr_next = {1'b0,
                    flags_q[OSC_BIT] & ev.flag_wdata[OSC_BIT],
                    flags_q[5:1],
                    flags_q[COLD_WARM_BIT] | ev.flag_wdata[COLD_WARM_BIT]};
  assign flags_d = ev.valid ? ev_next : (ev.flag_wr ? wr_next : flags_q);
  assign ev.flags = flags_q;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      flags_q <= 8'h00;
    else
      flags_q <= flags_d;
  end

endmodule : rst_flag_reg

// file: tb/rst_ctl_props.sv
// Checker of bus, reset release and pin rules of the reset controller.
`timescale 1ns/1ns
module rst_ctl_props
  import rst_ctl_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        reset_pin_b,
  input wire logic        lowvolt0_ok,
  input wire logic [1:0]  proc_mode,
  input wire logic        cpu_reset_b,
  input wire logic        cpu_clk_en,
  input wire logic        chip_select_zero_o,
  input wire logic        write_strobe_o,
  input wire logic        read_strobe_o,
  input wire logic        addr_latch_en_o,
  input wire logic        bus_pins_oe_b,
  input wire logic        port4_pullup_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire acc = psel && penable && pready;
  wire hit = paddr == RESET_SOURCE_FLAGS_ADDR || paddr == OPTION_SELECT_ADDR;
  wire mapped = hit || paddr == CONTROL_STATUS_ADDR;
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("No ready in access cycle");
  chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("Unmapped access without error");
  chk_rsvd_zero: assert property (acc && !pwrite && paddr == RESET_SOURCE_FLAGS_ADDR
    |-> prdata[31:7] == 25'h0)
    else $error("Reserved flag bits not zero");
  chk_pin_holds: assert property (!reset_pin_b [*3] |=> !cpu_reset_b)
    else $error("CPU runs while pin low");
  chk_release_cause: assert property ($rose(cpu_reset_b) |-> reset_pin_b && lowvolt0_ok)
    else $error("CPU released without cause");
  chk_clk_quiet: assert property (!cpu_reset_b [*2] |-> !cpu_clk_en)
    else $error("CPU clock while held");
  chk_ale_low: assert property (!addr_latch_en_o)
    else $error("Address latch enable high");
  chk_micro_pins: assert property ((!reset_pin_b && proc_mode == MODE_MICRO) [*3] |=>
    chip_select_zero_o && write_strobe_o && read_strobe_o && !bus_pins_oe_b && port4_pullup_en)
    else $error("Bus pins wrong in reset");
  chk_ports_input: assert property ((proc_mode != MODE_MICRO) [*3] |=> bus_pins_oe_b)
    else $error("Pins driven outside bus mode");
endmodule : rst_ctl_props

bind rst_ctl rst_ctl_props u_props (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .reset_pin_b, .lowvolt0_ok, .proc_mode, .cpu_reset_b, .cpu_clk_en,
  .chip_select_zero_o, .write_strobe_o, .read_strobe_o, .addr_latch_en_o, .bus_pins_oe_b,
  .port4_pullup_en);

// file: tb/reset_pin_model.sv
// Model of the reset pin circuit and slow oscillator facing the reset controller.
`timescale 1ns/1ns
module reset_pin_model #(
  parameter int MIN_LOW = 4
)
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic pin_req,
  output logic      reset_pin_b,
  output logic      slow_internal_osc_tick
);
  logic [1:0] div_q;
  logic [3:0] low_q;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_q <= 2'h0;
      low_q <= 4'h0;
      reset_pin_b <= 1'b1;
      slow_internal_osc_tick <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      slow_internal_osc_tick <= div_q == 2'h3;
      if (pin_req)
      begin
        reset_pin_b <= 1'b0;
        low_q <= 4'(MIN_LOW);
      end
      else if (low_q != 4'h0)
        low_q <= low_q - 4'h1;
      else
        reset_pin_b <= 1'b1;
    end
  end
endmodule : reset_pin_model

// file: tb/tb_top.sv
// Self-checking bench of the reset controller.
`timescale 1ns/1ns
module tb_top
  import rst_ctl_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, pin_b, tick, run, clk_en, cp_act, cs0, wrs, rds, oe_b, pu;
  logic        wd_as, csp, lv0_th, lv0_st, ale, bclk;
  logic        pin_req = 1'b0;
  logic [5:0]  trips = 6'h00;
  logic [1:0]  mode = MODE_SINGLE;
  int          n_mismatch = 0;
  int          checks = 0;
  int          pos [5] = '{LV1_BIT, LV2_BIT, WD_BIT, SW_BIT, OSC_BIT};

  always #2 sys_clk = ~sys_clk;

  // Option byte keeps the monitor 0 reset enabled for power-on use.
  rst_ctl #(.OPTION_BYTE(8'h36), .POR_COUNT(2)) u_dut (.sys_clk, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .reset_pin_b(pin_b),
    .lowvolt0_ok(1'b1), .lowvolt0_trip(trips[5]), .lowvolt1_trip(trips[0]),
    .lowvolt2_trip(trips[1]), .osc_stop_trip(trips[4]), .watchdog_trip(trips[2]),
    .sw_reset_req(trips[3]), .slow_internal_osc_tick(tick), .proc_mode(mode),
    .cpu_reset_b(run), .cpu_clk_en(clk_en), .watchdog_autostart_sel(wd_as),
    .count_source_protect_sel(csp), .code_protect_active(cp_act),
    .lowvolt0_threshold_sel(lv0_th), .lowvolt0_start_sel(lv0_st),
    .chip_select_zero_o(cs0), .write_strobe_o(wrs), .read_strobe_o(rds),
    .addr_latch_en_o(ale), .bus_clk_o(bclk), .bus_pins_oe_b(oe_b),
    .port4_pullup_en(pu));

  reset_pin_model u_pin (.sys_clk, .rst_b, .pin_req, .reset_pin_b(pin_b),
    .slow_internal_osc_tick(tick));

  task automatic end_of_test;
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bail(input bit hit);
    if (hit)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask : bail

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    i = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && i < 50)
    begin
      @(posedge sys_clk);
      i++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    bail(i >= 50);
  endtask : apb

  task automatic wait_run;
    int i;
    i = 0;
    while (run !== 1'b1 && i < 400)
    begin
      @(negedge sys_clk);
      i++;
    end
    bail(i >= 400);
  endtask : wait_run

  task automatic pulse(input int k);
    @(posedge sys_clk);
    trips[k] <= 1'b1;
    @(posedge sys_clk);
    trips[k] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse

  task automatic t_power_on;
    wait_run();
    apb(1'b0, RESET_SOURCE_FLAGS_ADDR, 32'h0);
    check(rd, 32'h0);
    check({31'h0, cp_act}, 32'h1);
    check({28'h0, lv0_st, lv0_th, csp, wd_as}, 32'hf);
    apb(1'b1, OPTION_SELECT_ADDR, 32'h0);
    apb(1'b0, OPTION_SELECT_ADDR, 32'h0);
    check(rd, 32'h36);
    apb(1'b1, RESET_SOURCE_FLAGS_ADDR, 32'h7f);
    apb(1'b0, RESET_SOURCE_FLAGS_ADDR, 32'h0);
    check(rd, 32'h01);
    apb(1'b0, 12'h100, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask : t_power_on

  task automatic t_cpu_clock;
    int i, n;
    i = 0;
    n = 1;
    while (clk_en !== 1'b1 && i < 100)
    begin
      @(negedge sys_clk);
      i++;
    end
    @(negedge sys_clk);
    while (clk_en !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
    end
    bail(i >= 100);
    check(32'(n), 32'(4 * CPU_CLK_DIV));
  endtask : t_cpu_clock

  task automatic t_sources;
    for (int k = 0; k < 5; k++)
    begin
      pulse(k);
      apb(1'b0, RESET_SOURCE_FLAGS_ADDR, 32'h0);
      check(rd, 32'h1 | (32'h1 << pos[k]));
    end
  endtask : t_sources

  task automatic t_pin_reset;
    logic b0;
    @(posedge sys_clk);
    mode <= MODE_MICRO;
    pin_req <= 1'b1;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    check({25'h0, cs0, wrs, rds, oe_b, pu, cp_act, ale}, 32'h74);
    check({28'h0, lv0_st, lv0_th, csp, wd_as}, 32'h0);
    check({31'h0, run}, 32'h0);
    b0 = bclk;
    @(negedge sys_clk);
    check({31'h0, bclk}, {31'h0, !b0});
    @(posedge sys_clk);
    pin_req <= 1'b0;
    mode <= MODE_SINGLE;
    wait_run();
    apb(1'b0, RESET_SOURCE_FLAGS_ADDR, 32'h0);
    check(rd, 32'h43);
    apb(1'b1, RESET_SOURCE_FLAGS_ADDR, 32'h0);
    apb(1'b0, RESET_SOURCE_FLAGS_ADDR, 32'h0);
    check(rd, 32'h03);
  endtask : t_pin_reset

  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_power_on();
    t_cpu_clock();
    t_sources();
    t_pin_reset();
    pulse(5);
    wait_run();
    apb(1'b0, RESET_SOURCE_FLAGS_ADDR, 32'h0);
    check(rd, 32'h0);
    end_of_test();
  end
endmodule : tb_top
